// [hw/trig_qual.sv]
/*
 Trigger qualifier: synchronises comparator outputs, evaluates edge,
 pattern, timed pattern and state conditions, applies delay and holdoff,
 and issues one trigger or auto-start pulse per qualified event.
 Assumes comparator outputs may be asynchronous and APB runs on ref_clk_i.
*/
`default_nettype none
module trig_qual (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Comparators: ch0..3, external, auxiliary, line
   input wire logic [6:0] cmp_i,
   // Analog front end control
   output logic [6:0] force_dc_o,
   output logic hyst_up_o,
   // Acquisition controller
   output logic trig_o,
   output logic auto_start_o,
   output logic [1:0] ref_pos_o
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [31:0] ctrl_r, src_r, pat_r, hold_r, tlo_r, thi_r, dly_r;
   logic [31:0] a_ctrl_r, a_src_r, a_pat_r, a_hold_r, a_tlo_r, a_thi_r, a_dly_r;
   logic armed_r, trig_seen_r;
   logic [31:0] trig_cnt_r;
   trig_qual_pkg::arm_state_t st_r;
   // Write lands only at the edge where the master sees pready
   wire wr = psel_i & penable_i & pwrite_i & pready_o;
   wire arm_pulse = wr && paddr_i == trig_qual_pkg::OFS_CTRL && pwdata_i[trig_qual_pkg::CTRL_ARM];

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ctrl_r <= 32'h0000_0000;
         src_r <= 32'h0000_0000;
         pat_r <= 32'h0000_0000;
         hold_r <= 32'h0000_0000;
         tlo_r <= 32'h0000_0000;
         thi_r <= 32'h0000_0000;
         dly_r <= 32'h0000_0000;
      end else if (wr) begin
         case (paddr_i)
            trig_qual_pkg::OFS_CTRL: ctrl_r <= pwdata_i;
            trig_qual_pkg::OFS_SRC: src_r <= pwdata_i;
            trig_qual_pkg::OFS_PAT: pat_r <= pwdata_i;
            trig_qual_pkg::OFS_HOLD: hold_r <= pwdata_i;
            trig_qual_pkg::OFS_TLO: tlo_r <= pwdata_i;
            trig_qual_pkg::OFS_THI: thi_r <= pwdata_i;
            trig_qual_pkg::OFS_DLY: dly_r <= pwdata_i;
            default: ;
         endcase
      end
   end

   // shadow at arm
   // Live copies only reach the logic at arm, so a half-written setup never fires
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         a_ctrl_r <= 32'h0000_0000;
         a_src_r <= 32'h0000_0000;
         a_pat_r <= 32'h0000_0000;
         a_hold_r <= 32'h0000_0000;
         a_tlo_r <= 32'h0000_0000;
         a_thi_r <= 32'h0000_0000;
         a_dly_r <= 32'h0000_0000;
      end else if (arm_pulse) begin
         a_ctrl_r <= pwdata_i;
         a_src_r <= src_r;
         a_pat_r <= pat_r;
         a_hold_r <= hold_r;
         a_tlo_r <= tlo_r;
         a_thi_r <= thi_r;
         a_dly_r <= dly_r;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i & ~pready_o;
         pslverr_o <= psel_i & ~pready_o & (paddr_i > trig_qual_pkg::OFS_STAT);
         case (paddr_i)
            trig_qual_pkg::OFS_CTRL: prdata_o <= ctrl_r;
            trig_qual_pkg::OFS_SRC: prdata_o <= src_r;
            trig_qual_pkg::OFS_PAT: prdata_o <= pat_r;
            trig_qual_pkg::OFS_HOLD: prdata_o <= hold_r;
            trig_qual_pkg::OFS_TLO: prdata_o <= tlo_r;
            trig_qual_pkg::OFS_THI: prdata_o <= thi_r;
            trig_qual_pkg::OFS_DLY: prdata_o <= dly_r;
            trig_qual_pkg::OFS_STAT: prdata_o <= {trig_cnt_r[27:0], trig_seen_r, st_r, armed_r};
            default: prdata_o <= 32'h0000_0000;
         endcase
      end
   end
   // Note: pready_o is registered, so it rises in the first access cycle and each transfer lasts two cycles.

   // ---------------------------------------------------------------
   // Input synchroniser and edge detection
   // ---------------------------------------------------------------
   logic [6:0] s1_r, s2_r, s3_r;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         s1_r <= 7'h00;
         s2_r <= 7'h00;
         s3_r <= 7'h00;
      end else begin
         s1_r <= cmp_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   wire [6:0] rise = s2_r & ~s3_r;
   wire [6:0] fall = ~s2_r & s3_r;

   function automatic logic sel_edge(input logic [6:0] r, input logic [6:0] f,
                                     input logic [2:0] idx, input logic falling);
      sel_edge = falling ? f[idx] : r[idx];
   endfunction : sel_edge

   function automatic logic pat_match(input logic [4:0] v, input logic [31:0] p);
      pat_match = ((v ^ p[4:0]) & p[12:8]) == 5'h00;
   endfunction : pat_match

   // ---------------------------------------------------------------
   // Qualifying conditions
   // ---------------------------------------------------------------
   wire [2:0] mode = a_ctrl_r[trig_qual_pkg::CTRL_MODE_LO +: 3];
   wire [2:0] qmode = a_ctrl_r[trig_qual_pkg::CTRL_MODE_LO + 4 +: 3];
   wire [1:0] qcmp = a_ctrl_r[trig_qual_pkg::CTRL_QCMP_LO +: 2];
   wire [2:0] src = a_src_r[2:0];
   wire [2:0] dsrc = a_src_r[trig_qual_pkg::SRC_DLY_LO +: 3];
   logic m_now, m_prev_r;
   logic [trig_qual_pkg::CNT_W-1:0] dur_r;
   assign m_now = pat_match(s2_r[4:0], a_pat_r);
   // one cycle of 4 ns already exceeds 1.75 ns
   // a 1 ns pulse is stretched by the comparator path to at least one sample
   wire p_enter = m_now & ~m_prev_r;
   wire p_exit = ~m_now & m_prev_r;
   // duration counter reloads on every entry, zero recovery
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || arm_pulse) begin
         m_prev_r <= 1'b0;
         dur_r <= '0;
      end else begin
         m_prev_r <= m_now;
         if (p_enter)
            dur_r <= 27'h000_0001;
         else if (m_now && dur_r != '1)
            dur_r <= dur_r + 27'h000_0001;
      end
   end
   // limits in cycles, 27 bits reach 320 ms
   wire lt_ok = dur_r < a_tlo_r[26:0];
   wire gt_ok = dur_r > a_thi_r[26:0];
   logic tq_ok;
   always_comb begin
      case (qcmp)
         trig_qual_pkg::QCMP_LT: tq_ok = lt_ok;
         trig_qual_pkg::QCMP_GT: tq_ok = gt_ok;
         trig_qual_pkg::QCMP_RANGE: tq_ok = gt_ok & lt_ok;
         default: tq_ok = 1'b0;
      endcase
   end
   // clock input chosen by src, its value dropped from the pattern
   wire st_clk = sel_edge(rise, fall, src, a_ctrl_r[trig_qual_pkg::CTRL_FALL]);
   logic [31:0] st_pat;
   always_comb begin
      st_pat = a_pat_r;
      if (src < 3'h5)
         st_pat[8 + src] = 1'b0;
   end
   wire st_hit = st_clk & (pat_match(s3_r[4:0], st_pat) ^ a_ctrl_r[trig_qual_pkg::CTRL_ABSENT]);

   function automatic logic cond_of(input logic [2:0] m, input logic edg, input logic en,
                                    input logic ex, input logic exit_sel, input logic tq,
                                    input logic st);
      case (m)
         trig_qual_pkg::MODE_EDGE: cond_of = edg;
         trig_qual_pkg::MODE_PAT: cond_of = exit_sel ? ex : en;
         trig_qual_pkg::MODE_TPAT: cond_of = ex & tq;
         trig_qual_pkg::MODE_STATE: cond_of = st;
         default: cond_of = 1'b0;
      endcase
   endfunction : cond_of

   wire edg = sel_edge(rise, fall, src, a_ctrl_r[trig_qual_pkg::CTRL_FALL]);
   wire direct = cond_of(mode, edg, p_enter, p_exit, a_ctrl_r[trig_qual_pkg::CTRL_EXIT], tq_ok, st_hit);
   wire qual = cond_of(qmode, edg, p_enter, p_exit, a_ctrl_r[trig_qual_pkg::CTRL_EXIT], tq_ok, st_hit);
   // one event per cycle at 250 MHz covers 70 MHz
   wire dly_edge = sel_edge(rise, fall, dsrc, a_ctrl_r[trig_qual_pkg::CTRL_DFALL]);
   wire delayed = mode == trig_qual_pkg::MODE_EVDLY || mode == trig_qual_pkg::MODE_TMDLY;

   // ---------------------------------------------------------------
   // Arm, delay and holdoff sequencer
   // ---------------------------------------------------------------
   logic [trig_qual_pkg::CNT_W-1:0] cnt_r;
   logic [25:0] auto_r;
   logic [26:0] hold_lim;
   wire hold_ev = a_ctrl_r[trig_qual_pkg::CTRL_HOLD_EV] && !delayed;
   wire no_hold = src == trig_qual_pkg::SRC_AUX || src == trig_qual_pkg::SRC_LINE;
   // delayed mode uses fixed holdoff, others their own setting
   assign hold_lim = delayed ? trig_qual_pkg::DLY_HOLD_CYC : a_hold_r[26:0];
   wire fire_now = (st_r == trig_qual_pkg::ST_WAIT && !delayed && direct) ||
                   (st_r == trig_qual_pkg::ST_DELAY && dly_edge &&
                    cnt_r >= a_dly_r[26:0]);
   // auto timeout
   // Fixed at about 50 ms, so short runs only see the disabled case
   wire auto_fire = st_r == trig_qual_pkg::ST_WAIT && a_ctrl_r[trig_qual_pkg::CTRL_AUTO] &&
                    auto_r == 26'(trig_qual_pkg::AUTO_TMO_CYC - 1);

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st_r <= trig_qual_pkg::ST_IDLE;
         cnt_r <= '0;
         auto_r <= 26'h000_0000;
         armed_r <= 1'b0;
      end else if (arm_pulse) begin
         st_r <= trig_qual_pkg::ST_WAIT;
         cnt_r <= '0;
         auto_r <= 26'h000_0000;
         armed_r <= 1'b1;
      end else begin
         // auto counter only runs with auto bit set
         if (st_r == trig_qual_pkg::ST_WAIT && a_ctrl_r[trig_qual_pkg::CTRL_AUTO] && !auto_fire)
            auto_r <= auto_r + 26'h000_0001;
         else
            auto_r <= 26'h000_0000;
         case (st_r)
            trig_qual_pkg::ST_IDLE: ;
            trig_qual_pkg::ST_WAIT: begin
               if (delayed && qual) begin
                  st_r <= trig_qual_pkg::ST_DELAY;
                  cnt_r <= '0;
               end else if (fire_now || auto_fire) begin
                  st_r <= no_hold ? trig_qual_pkg::ST_WAIT : trig_qual_pkg::ST_HOLD;
                  cnt_r <= '0;
               end
            end
            trig_qual_pkg::ST_DELAY: begin
               // event count, time count in cycles
               if (fire_now) begin
                  st_r <= trig_qual_pkg::ST_HOLD;
                  cnt_r <= '0;
               end else if (mode == trig_qual_pkg::MODE_TMDLY || dly_edge) begin
                  if (cnt_r != '1)
                     cnt_r <= cnt_r + 27'h000_0001;
               end
            end
            trig_qual_pkg::ST_HOLD: begin
               if (cnt_r >= hold_lim) begin
                  st_r <= trig_qual_pkg::ST_WAIT;
                  cnt_r <= '0;
               end else if (!hold_ev || direct) begin
                  cnt_r <= cnt_r + 27'h000_0001;
               end
            end
            default: st_r <= trig_qual_pkg::ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         trig_o <= 1'b0;
         auto_start_o <= 1'b0;
         force_dc_o <= 7'h00;
         hyst_up_o <= 1'b0;
         ref_pos_o <= 2'h0;
         trig_seen_r <= 1'b0;
         trig_cnt_r <= 32'h0000_0000;
      end else begin
         // Holdoff never lets a pulse out, even with a condition present
         trig_o <= fire_now && st_r != trig_qual_pkg::ST_HOLD;
         auto_start_o <= auto_fire && !fire_now;
         force_dc_o <= {7{mode != trig_qual_pkg::MODE_EDGE}};
         hyst_up_o <= a_ctrl_r[trig_qual_pkg::CTRL_NREJ];
         ref_pos_o <= a_ctrl_r[trig_qual_pkg::CTRL_REF_LO +: 2];
         // A trigger in the arm cycle still counts: set wins over clear
         if (fire_now)
            trig_seen_r <= 1'b1;
         else if (arm_pulse)
            trig_seen_r <= 1'b0;
         if (arm_pulse)
            trig_cnt_r <= {31'h0000_0000, fire_now};
         else if (fire_now)
            trig_cnt_r <= trig_cnt_r + 32'h0000_0001;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Arm cycles are left out where a new snapshot would change the judged mode
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   no_self_start_a: assert property (!a_ctrl_r[trig_qual_pkg::CTRL_AUTO] |=> !auto_start_o)
      else $error("self start in triggered mode");
   hold_blocks_a: assert property (st_r == trig_qual_pkg::ST_HOLD |=> !trig_o)
      else $error("trigger during holdoff");
   dc_force_a: assert property (mode != trig_qual_pkg::MODE_EDGE |=> force_dc_o == 7'h7f)
      else $error("coupling not forced dc");
   no_hold_aux_a: assert property (st_r == trig_qual_pkg::ST_WAIT && fire_now && no_hold && !arm_pulse
      |=> st_r == trig_qual_pkg::ST_WAIT)
      else $error("holdoff on aux or line");
   edge_fire_a: assert property (st_r == trig_qual_pkg::ST_WAIT && mode == trig_qual_pkg::MODE_EDGE
      && edg && !arm_pulse |=> trig_o)
      else $error("edge missed");
   rearm_clear_a: assert property (arm_pulse |=> cnt_r == '0 && st_r == trig_qual_pkg::ST_WAIT)
      else $error("counters not cleared");
   hyst_a: assert property (arm_pulse |=> ##1 hyst_up_o == $past(pwdata_i[trig_qual_pkg::CTRL_NREJ], 2))
      else $error("hysteresis mismatch");
   dly_hold_a: assert property (delayed && st_r == trig_qual_pkg::ST_HOLD && cnt_r == 27'h000_0000
      && !arm_pulse |-> ##[1:12] st_r != trig_qual_pkg::ST_HOLD || arm_pulse)
      else $error("delayed holdoff too long");
   tpat_short_a: assert property (st_r == trig_qual_pkg::ST_WAIT && mode == trig_qual_pkg::MODE_TPAT
      && qcmp == trig_qual_pkg::QCMP_LT && p_exit && lt_ok && !arm_pulse |=> trig_o)
      else $error("short pattern missed");
   delay_count_a: assert property (st_r == trig_qual_pkg::ST_DELAY && mode == trig_qual_pkg::MODE_EVDLY
      && !dly_edge && !arm_pulse |=> $stable(cnt_r))
      else $error("delay count moved without edge");
   delay_fire_a: assert property (st_r == trig_qual_pkg::ST_DELAY && dly_edge && cnt_r >= a_dly_r[26:0]
      && !arm_pulse |=> trig_o)
      else $error("delayed trigger missed");
   pat_enter_a: assert property (st_r == trig_qual_pkg::ST_WAIT && mode == trig_qual_pkg::MODE_PAT
      && !a_ctrl_r[trig_qual_pkg::CTRL_EXIT] && p_enter && !arm_pulse |=> trig_o)
      else $error("pattern entry missed");
   event_hold_a: assert property (st_r == trig_qual_pkg::ST_HOLD && hold_ev && !direct && cnt_r < hold_lim
      && !arm_pulse |=> $stable(cnt_r))
      else $error("event holdoff counted a non-event");
   state_fire_a: assert property (st_r == trig_qual_pkg::ST_WAIT && mode == trig_qual_pkg::MODE_STATE
      && st_hit && !arm_pulse |=> trig_o)
      else $error("state trigger missed");
   ref_pos_a: assert property (arm_pulse |=> ##1
      ref_pos_o == $past(pwdata_i[trig_qual_pkg::CTRL_REF_LO +: 2], 2))
      else $error("reference position not taken at arm");
   edge_coupling_a: assert property (mode == trig_qual_pkg::MODE_EDGE |=> force_dc_o == 7'h00)
      else $error("coupling forced in edge mode");
   // ---------------------------------------------------------------
   // Cover points
   // ---------------------------------------------------------------
   cv_edge: cover property (trig_o && mode == trig_qual_pkg::MODE_EDGE);
   cv_auto: cover property (auto_start_o);
   cv_tpat: cover property (trig_o && mode == trig_qual_pkg::MODE_TPAT);
   cv_delay: cover property (st_r == trig_qual_pkg::ST_DELAY ##1 trig_o);
   cv_ev_hold: cover property (st_r == trig_qual_pkg::ST_HOLD && hold_ev && direct);
endmodule : trig_qual
`default_nettype wire

// [hw/trig_qual_pkg.sv]
/*
 Shared constants for the acquisition trigger qualifier: register map, field
 positions, mode encodings and timing counts derived from the 250 MHz clock.
 Assumes an APB master with 32-bit data and one aligned word per register.
*/
`default_nettype none
package trig_qual_pkg;
   localparam int CLK_MHZ = 250;
   localparam int NSRC = 7;   // 4 channels, external, auxiliary, line
   localparam int NPAT = 5;   // channels and external join patterns
   localparam logic [2:0] SRC_AUX = 3'h5;
   localparam logic [2:0] SRC_LINE = 3'h6;
   // Times in ns, cycle counts derived at 4 ns per cycle
   localparam int AUTO_TMO_NS = 50_000_000;
   // Divide first: the product would overflow a 32-bit int
   localparam int AUTO_TMO_CYC = AUTO_TMO_NS / 1000 * CLK_MHZ;
   localparam int DLY_HOLD_NS = 40;
   localparam logic [26:0] DLY_HOLD_CYC = 27'((DLY_HOLD_NS * CLK_MHZ + 999) / 1000);
   localparam int RECOVER_NS = 12;
   localparam int RECOVER_CYC = RECOVER_NS * CLK_MHZ / 1000;
   localparam int CNT_W = 27;   // 320 ms at 4 ns fits 27 bits
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SRC = 8'h04;
   localparam logic [7:0] OFS_PAT = 8'h08;
   localparam logic [7:0] OFS_HOLD = 8'h0C;
   localparam logic [7:0] OFS_TLO = 8'h10;
   localparam logic [7:0] OFS_THI = 8'h14;
   localparam logic [7:0] OFS_DLY = 8'h18;
   localparam logic [7:0] OFS_STAT = 8'h1C;
   // Control field positions
   localparam int CTRL_ARM = 0;
   localparam int CTRL_AUTO = 1;
   localparam int CTRL_NREJ = 2;
   localparam int CTRL_MODE_LO = 4;
   localparam int CTRL_EXIT = 8;
   localparam int CTRL_FALL = 9;
   localparam int CTRL_ABSENT = 10;
   localparam int CTRL_QCMP_LO = 12;
   localparam int CTRL_REF_LO = 16;
   localparam int CTRL_DFALL = 18;
   localparam int CTRL_HOLD_EV = 19;
   localparam int SRC_DLY_LO = 4;
   localparam int HOLD_W = 27;
   typedef enum logic [2:0] {
      MODE_EDGE = 3'b000, MODE_PAT = 3'b001, MODE_TPAT = 3'b010,
      MODE_STATE = 3'b011, MODE_EVDLY = 3'b100, MODE_TMDLY = 3'b101
   } trig_mode_t;
   typedef enum logic [1:0] {
      QCMP_LT = 2'b00, QCMP_GT = 2'b01, QCMP_RANGE = 2'b10
   } qual_cmp_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_DELAY = 2'b10, ST_HOLD = 2'b11
   } arm_state_t;
endpackage : trig_qual_pkg
`default_nettype wire

// [bench/acq_side_model.sv]
/*
 Stand-in for the comparators and the acquisition controller around the
 trigger qualifier. Comparator levels are set by task; pulses are tallied.
 Assumes it shares the qualifier's clock and is never reset itself.
*/
`default_nettype none
module acq_side_model (
   // Clock
   input wire logic clk_i,
   // From the qualifier
   input wire logic trig_i,
   input wire logic auto_i,
   // To the qualifier
   output var logic [6:0] cmp_o,
   // Pulse tallies, free running so the bench works on differences
   output var logic [31:0] trig_cnt_o,
   output var logic [31:0] auto_cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmp_o = 7'h00;
      trig_cnt_o = 32'h0000_0000;
      auto_cnt_o = 32'h0000_0000;
   end
   // Levels move just after an edge; the qualifier must synchronise them
   task automatic set_cmp(input logic [6:0] v);
      @(posedge clk_i);
      cmp_o <= v;
   endtask : set_cmp
   // A pulse held two cycles counts twice, so widths are checked too
   always @(posedge clk_i) begin
      if (trig_i === 1'b1) begin
         trig_cnt_o <= trig_cnt_o + 32'h0000_0001;
      end
      if (auto_i === 1'b1) begin
         auto_cnt_o <= auto_cnt_o + 32'h0000_0001;
      end
   end
endmodule : acq_side_model
`default_nettype wire

// [bench/testbench.sv]
/*
 Self-checking bench for the trigger qualifier: APB set-up, edge, holdoff,
 pattern and status checks against the comparator and controller model.
 Assumes APB answers in the access phase and outputs settle by the next edge.
*/
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, trig_cnt, auto_cnt, rdata, base;
   logic pready, pslverr, trig, auto_start, hyst_up, err;
   logic [6:0] force_dc, cmp;
   logic [1:0] ref_pos;
   int fails = 0;
   int checks_done = 0;
   localparam logic [31:0] ARM = 32'h0000_0001;
   always #2 ref_clk = ~ref_clk;
   trig_qual DUT (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .cmp_i(cmp), .force_dc_o(force_dc), .hyst_up_o(hyst_up), .trig_o(trig),
      .auto_start_o(auto_start), .ref_pos_o(ref_pos));
   acq_side_model acq (.clk_i(ref_clk), .trig_i(trig), .auto_i(auto_start), .cmp_o(cmp),
      .trig_cnt_o(trig_cnt), .auto_cnt_o(auto_cnt));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Request held until the edge where pready is seen; data taken there
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int i;
      @(posedge ref_clk);
      paddr <= addr;
      pwrite <= wr;
      pwdata <= wd;
      psel <= 1'b1;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         fails++;
         results();
      end
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic reset_dut();
      acq.set_cmp(7'h00);
      rst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
   endtask : reset_dut
   task automatic arm(input logic [31:0] ctrl);
      apb(1'b1, trig_qual_pkg::OFS_CTRL, ctrl | ARM);
      repeat (3) @(posedge ref_clk);
      base = trig_cnt;
   endtask : arm
   task automatic rise(input logic [6:0] v);
      acq.set_cmp(7'h00);
      acq.set_cmp(v);
      repeat (10) @(posedge ref_clk);
   endtask : rise
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      reset_dut();
      chk("outputs after reset", 32'h0000_0000, {20'h0_0000, trig, auto_start, hyst_up, force_dc, ref_pos});
      apb(1'b0, 8'hE0, 32'h0000_0000);
      chk("unmapped read data", 32'h0000_0000, rdata);
      chk("unmapped read error", 32'h0000_0001, {31'h0, err});
      arm((32'h0000_0001 << trig_qual_pkg::CTRL_NREJ) | (32'h0000_0002 << trig_qual_pkg::CTRL_REF_LO));
      chk("noise reject", 32'h0000_0001, {31'h0, hyst_up});
      chk("reference position", 32'h0000_0002, {30'h0, ref_pos});
      chk("coupling in edge mode", 32'h0000_0000, {25'h0, force_dc});
      apb(1'b0, trig_qual_pkg::OFS_STAT, 32'h0000_0000);
      chk("armed flag", 32'h0000_0001, {31'h0, rdata[0]});
      apb(1'b1, trig_qual_pkg::OFS_DLY, 32'hA5C3_9617);
      apb(1'b0, trig_qual_pkg::OFS_DLY, 32'h0000_0000);
      chk("delay register readback", 32'hA5C3_9617, rdata);
      // Mode change without arm must not reach the front end
      apb(1'b1, trig_qual_pkg::OFS_CTRL, 32'h0000_0001 << trig_qual_pkg::CTRL_MODE_LO);
      repeat (3) @(posedge ref_clk);
      chk("late config", 32'h0000_0080, {24'h0, hyst_up, force_dc});
      $display("t_regs done");
   endtask : t_regs
   task automatic t_edge(input logic fall);
      reset_dut();
      apb(1'b1, trig_qual_pkg::OFS_SRC, 32'h0000_0000);
      apb(1'b1, trig_qual_pkg::OFS_HOLD, 32'h0000_0000);
      arm({22'h0, fall, 9'h000});
      rise(7'h01);
      chk("edge on rise", {31'h0, !fall}, trig_cnt - base);
      acq.set_cmp(7'h00);
      repeat (10) @(posedge ref_clk);
      chk("edge after fall", 32'h0000_0001, trig_cnt - base);
      base = auto_cnt;
      repeat (3000) @(posedge ref_clk);
      chk("no self start", 32'h0000_0000, auto_cnt - base);
      $display("t_edge done");
   endtask : t_edge
   // Second edge falls inside the 50 cycle holdoff, third well after it
   task automatic t_hold(input logic [2:0] src, input logic [31:0] mid);
      reset_dut();
      apb(1'b1, trig_qual_pkg::OFS_SRC, {29'h0, src});
      apb(1'b1, trig_qual_pkg::OFS_HOLD, 32'h0000_0032);
      arm(32'h0000_0000);
      rise(7'h01 << src);
      chk("first trigger", 32'h0000_0001, trig_cnt - base);
      rise(7'h01 << src);
      chk("edge in holdoff", mid, trig_cnt - base);
      repeat (60) @(posedge ref_clk);
      rise(7'h01 << src);
      chk("edge after holdoff", mid + 32'h0000_0001, trig_cnt - base);
      $display("t_hold done");
   endtask : t_hold
   // Seven rises at 62.5 MHz: accepted are the first, fourth and seventh
   task automatic t_evhold();
      int i;
      reset_dut();
      apb(1'b1, trig_qual_pkg::OFS_SRC, 32'h0000_0000);
      apb(1'b1, trig_qual_pkg::OFS_HOLD, 32'h0000_0002);
      arm(32'h0000_0001 << trig_qual_pkg::CTRL_HOLD_EV);
      for (i = 0; i < 7; i++) begin
         acq.set_cmp(7'h01);
         @(posedge ref_clk);
         acq.set_cmp(7'h00);
         @(posedge ref_clk);
      end
      repeat (10) @(posedge ref_clk);
      chk("event holdoff", 32'h0000_0003, trig_cnt - base);
      $display("t_evhold done");
   endtask : t_evhold
   // Channel 0 high, channel 1 low, the rest ignored
   task automatic t_pat(input logic on_exit);
      reset_dut();
      apb(1'b1, trig_qual_pkg::OFS_PAT, 32'h0000_0301);
      arm((32'h0000_0001 << trig_qual_pkg::CTRL_MODE_LO) | {23'h0, on_exit, 8'h00});
      chk("coupling forced dc", 32'h0000_007F, {25'h0, force_dc});
      acq.set_cmp(7'h04);
      repeat (10) @(posedge ref_clk);
      chk("ignored input", 32'h0000_0000, trig_cnt - base);
      acq.set_cmp(7'h05);
      repeat (10) @(posedge ref_clk);
      chk("pattern entry", {31'h0, !on_exit}, trig_cnt - base);
      acq.set_cmp(7'h07);
      repeat (10) @(posedge ref_clk);
      chk("pattern exit", 32'h0000_0001, trig_cnt - base);
      $display("t_pat done");
   endtask : t_pat
   // External high, ch3 low: a 2 cycle match beats the shorter-than limit, an 11 cycle one does not
   task automatic t_tpat();
      reset_dut();
      apb(1'b1, trig_qual_pkg::OFS_PAT, 32'h0000_1810);
      apb(1'b1, trig_qual_pkg::OFS_TLO, 32'h0000_0005);
      arm(32'h0000_0002 << trig_qual_pkg::CTRL_MODE_LO);
      acq.set_cmp(7'h10);
      @(posedge ref_clk);
      acq.set_cmp(7'h18);
      repeat (10) @(posedge ref_clk);
      chk("short pattern", 32'h0000_0001, trig_cnt - base);
      acq.set_cmp(7'h10);
      repeat (10) @(posedge ref_clk);
      acq.set_cmp(7'h18);
      repeat (10) @(posedge ref_clk);
      chk("long pattern", 32'h0000_0001, trig_cnt - base);
      $display("t_tpat done");
   endtask : t_tpat
   // A ch1 rise before the ch0 qualifier is ignored; two ch1 rises counted, the third fires
   task automatic t_evdly();
      reset_dut();
      apb(1'b1, trig_qual_pkg::OFS_SRC, 32'h0000_0010);
      apb(1'b1, trig_qual_pkg::OFS_DLY, 32'h0000_0002);
      arm(32'h0000_0004 << trig_qual_pkg::CTRL_MODE_LO);
      rise(7'h02);
      rise(7'h01);
      rise(7'h02);
      rise(7'h02);
      chk("delay count", 32'h0000_0000, trig_cnt - base);
      rise(7'h02);
      chk("delayed trigger", 32'h0000_0001, trig_cnt - base);
      $display("t_evdly done");
   endtask : t_evdly
   initial begin
      t_regs();
      t_edge(1'b0);
      t_edge(1'b1);
      t_hold(3'h0, 32'h0000_0001);
      t_hold(trig_qual_pkg::SRC_AUX, 32'h0000_0002);
      t_hold(trig_qual_pkg::SRC_LINE, 32'h0000_0002);
      t_hold(3'h4, 32'h0000_0001);
      t_evhold();
      t_pat(1'b0);
      t_pat(1'b1);
      t_tpat();
      t_evdly();
      results();
   end
endmodule : testbench
`default_nettype wire
